// file: inc/rcs_consts.svh
// constants for the reset cause and debug force reset block
`ifndef RCS_CONSTS_SVH
`define RCS_CONSTS_SVH
// ----------------------------------------
// register offsets (byte addresses on the 8-bit system bus)
// ----------------------------------------
`define RCS_OFS_CAUSE 16'h3000
`define RCS_OFS_FORCE 16'h3001
// ----------------------------------------
// cause register bit positions
// ----------------------------------------
`define RCS_BIT_POWERON 7
`define RCS_BIT_PIN 6
`define RCS_BIT_WATCHDOG 5
`define RCS_BIT_OPCODE 4
`define RCS_BIT_ADDR 3
`define RCS_BIT_OSC 2
`define RCS_BIT_BROWN 1
`define RCS_BIT_FORCE 0
// ----------------------------------------
// reset values
// ----------------------------------------
`define RCS_CAUSE_POR 8'h82
`define RCS_ZERO 8'h00
`endif

// file: inc/rcs_pkg.sv
// types for the reset cause and debug force reset block
package rcs_pkg;
  typedef logic [7:0] rcs_byte_t;
  typedef logic [15:0] rcs_addr_t;
  typedef enum logic [1:0] {
    RCS_RUN = 2'b00,
    RCS_HOLD = 2'b01,
    RCS_DONE = 2'b11
  } rcs_state_t;
endpackage

// file: src/rcs_sync.sv
// three-flop synchroniser with agreement of last two stages
`timescale 1ns/100ps
`default_nettype none
module rcs_sync (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // async level in, filtered level out
  input wire logic din,
  output logic dout
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        dout <= s3_q;
      end
    end
  end
endmodule // rcs_sync
`default_nettype wire

// file: src/rcs_top.sv
// reset cause capture and debug-forced reset request
// Notes on behaviour
// - bit 7 reads 1 after power-on reset, 0 otherwise
// - bit 6 reads 1 after an external reset pin reset
// - bit 5 flags watchdog reset; none while watchdog enable is cleared
// - bit 4 flags reset from an illegal or unimplemented opcode
// - halt instruction with halt enable cleared counts as illegal opcode
// - debug halt instruction with debug mode disabled counts as illegal opcode
// - bit 3 flags illegal address reset; address captured elsewhere
// - bit 2 flags a reset asked for by the clock unit
// - brownout reset needs enable in run, both enables in stop; bit 1
// - bit 1 also set by power-on and undervoltage, cleared otherwise
// - reserved cause bit 0 and force bits 7-1 read zero
// - processor writes to the force register are ignored
// - reads of the force register always return zero
// - debug host writing 1 to force bit 0 requests full reset, except in the RCS_DONE cycle
// - a debug forced reset leaves all cause flags cleared
// - pin, watchdog, opcode flags follow sources active at reset time
`timescale 1ns/100ps
`default_nettype none
`include "rcs_consts.svh"
module rcs_top (
  // clock and power-on reset
  input wire logic core_clk,
  input wire logic rstn,
  // cpu bus
  input wire rcs_pkg::rcs_addr_t cpu_addr,
  input wire rcs_pkg::rcs_byte_t cpu_wdata,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  output rcs_pkg::rcs_byte_t cpu_rdata,
  // serial background debug write port
  input wire rcs_pkg::rcs_addr_t dbg_addr,
  input wire rcs_pkg::rcs_byte_t dbg_wdata,
  input wire logic dbg_wr,
  // reset sources
  input wire logic reset_pin_n,
  input wire logic watchdog_timeout,
  input wire logic watchdog_enable,
  input wire logic opcode_illegal,
  input wire logic halt_exec,
  input wire logic halt_enable,
  input wire logic debug_halt_instruction,
  input wire logic debug_mode_enable,
  input wire logic address_illegal,
  input wire logic osc_reset_req,
  input wire logic supply_low,
  input wire logic stop_mode,
  input wire logic brownout_reset_enable,
  input wire logic brownout_stop_enable,
  input wire logic undervoltage_reset,
  // reset request to the reset generator and its active window
  output logic mcu_reset_req,
  output logic sys_reset_active
);
  import rcs_pkg::*;

  // ----------------------------------------
  // pin synchroniser
  // ----------------------------------------
  logic pin_low;
  rcs_sync u_pin_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .din(~reset_pin_n),
    .dout(pin_low)
  );

  // ----------------------------------------
  // source qualification
  // ----------------------------------------
  logic watchdog_src;
  logic opcode_src;
  logic brown_src;
  logic force_src;
  logic any_src;
  assign watchdog_src = watchdog_timeout & watchdog_enable;
  assign opcode_src = opcode_illegal
    | (halt_exec & ~halt_enable)
    | (debug_halt_instruction & ~debug_mode_enable);
  assign brown_src = supply_low & brownout_reset_enable
    & (~stop_mode | brownout_stop_enable);
  // only the debug port reaches the force bit; cpu writes never do
  assign force_src = dbg_wr && (dbg_addr == `RCS_OFS_FORCE)
    && dbg_wdata[`RCS_BIT_FORCE];
  assign any_src = pin_low | watchdog_src | opcode_src | address_illegal
    | osc_reset_req | brown_src | undervoltage_reset | force_src;

  // ----------------------------------------
  // reset sequencing
  // ----------------------------------------
  rcs_state_t st_q;
  logic force_seen_q;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= RCS_RUN;
    end else begin
      case (st_q)
        RCS_RUN: if (any_src) st_q <= RCS_HOLD;
        RCS_HOLD: if (!any_src) st_q <= RCS_DONE;
        RCS_DONE: st_q <= RCS_RUN;
        default: st_q <= RCS_RUN;
      endcase
    end
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      force_seen_q <= 1'b0;
    end else if (st_q == RCS_RUN) begin
      force_seen_q <= force_src;
    end else if (st_q == RCS_HOLD && force_src) begin
      force_seen_q <= 1'b1;
    end else if (st_q == RCS_DONE) begin
      // a stale mark would blank the flags of the next window
      force_seen_q <= 1'b0;
    end
  end
  assign mcu_reset_req = (st_q == RCS_RUN) && any_src;
  assign sys_reset_active = (st_q == RCS_HOLD);

  // ----------------------------------------
  // cause flags
  // ----------------------------------------
  // flags follow the sources on each window cycle with a source active;
  // the quiet closing cycle must not load, or every flag would be lost
  rcs_byte_t cause_q;
  rcs_byte_t cause_d;
  always_comb begin
    cause_d = `RCS_ZERO;
    cause_d[`RCS_BIT_PIN] = pin_low;
    cause_d[`RCS_BIT_WATCHDOG] = watchdog_src;
    cause_d[`RCS_BIT_OPCODE] = opcode_src;
    cause_d[`RCS_BIT_ADDR] = address_illegal;
    cause_d[`RCS_BIT_OSC] = osc_reset_req;
    cause_d[`RCS_BIT_BROWN] = brown_src | undervoltage_reset;
    if (force_src || force_seen_q) begin
      cause_d = `RCS_ZERO;
    end
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cause_q <= `RCS_CAUSE_POR;
    end else if (any_src && (st_q == RCS_RUN || st_q == RCS_HOLD)) begin
      cause_q <= cause_d;
    end
  end

  // ----------------------------------------
  // cpu read port
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cpu_rdata <= `RCS_ZERO;
    end else if (cpu_rd && cpu_addr == `RCS_OFS_CAUSE) begin
      cpu_rdata <= {cause_q[7:1], 1'b0};
    end else begin
      cpu_rdata <= `RCS_ZERO;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_force;
    @(posedge core_clk) disable iff (!rstn)
    (st_q == RCS_RUN && force_src) |=> (st_q == RCS_HOLD);
  endproperty
  force_reset_req_a: assert property (p_force) else $error("force not taken");
  force_clears_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (st_q != RCS_DONE && force_src) |=> (cause_q == `RCS_ZERO))
    else $error("force left flags");
  force_read_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (cpu_rd && cpu_addr == `RCS_OFS_FORCE) |=> (cpu_rdata == `RCS_ZERO))
    else $error("force read nonzero");
  cause_bit0_a: assert property (@(posedge core_clk) disable iff (!rstn)
    cpu_rdata[0] == 1'b0) else $error("reserved bit set");
  cause_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (st_q == RCS_RUN && !any_src) |=> $stable(cause_q))
    else $error("flags changed");
  // a cpu store of a one to the force bit while every source is quiet
  cpu_write_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (st_q == RCS_RUN && cpu_wr && cpu_addr == `RCS_OFS_FORCE && cpu_wdata[`RCS_BIT_FORCE]
     && !dbg_wr && !pin_low && !watchdog_src && !opcode_src && !address_illegal
     && !osc_reset_req && !brown_src && !undervoltage_reset) |-> !mcu_reset_req)
    else $error("cpu write reset");
  watchdog_gate_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (st_q != RCS_DONE && any_src && !watchdog_enable) |=> !cause_q[`RCS_BIT_WATCHDOG])
    else $error("watchdog flag while disabled");
  sequence s_halt_bad;
    halt_exec && !halt_enable && st_q == RCS_HOLD && !force_src && !force_seen_q;
  endsequence
  halt_opcode_a: assert property (@(posedge core_clk) disable iff (!rstn)
    s_halt_bad |=> cause_q[`RCS_BIT_OPCODE]) else $error("halt not illegal");
  debug_opcode_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (debug_halt_instruction && !debug_mode_enable && st_q == RCS_HOLD
     && !force_src && !force_seen_q) |=> cause_q[`RCS_BIT_OPCODE])
    else $error("debug halt not illegal");
endmodule // rcs_top
`default_nettype wire

// file: dv/rcs_host_model.sv
// serial background debug host model
`timescale 1ns/100ps
`default_nettype none
`include "rcs_consts.svh"
module rcs_host_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // command from bench
  input wire logic go,
  input wire rcs_pkg::rcs_byte_t data,
  // debug write port
  output rcs_pkg::rcs_addr_t dbg_addr,
  output rcs_pkg::rcs_byte_t dbg_wdata,
  output logic dbg_wr
);
  import rcs_pkg::*;
  // idle bus toggles, so the stale address comes back every other cycle with dbg_wr low
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dbg_wr <= 1'b0;
      dbg_addr <= 16'h0000;
      dbg_wdata <= 8'h00;
    end else begin
      dbg_wr <= go;
      dbg_addr <= go ? `RCS_OFS_FORCE : ~dbg_addr;
      dbg_wdata <= go ? data : ~dbg_wdata;
    end
  end
endmodule // rcs_host_model
`default_nettype wire

// file: dv/tb.sv
// random and corner testbench for the reset cause block
`timescale 1ns/100ps
`default_nettype none
module tb;
  import rcs_pkg::*;
  logic core_clk = 1'b0, rstn = 1'b0, go = 1'b0, cpu_wr = 1'b0, cpu_rd = 1'b0, seen = 1'b0;
  logic dbg_wr, mcu_reset_req, sys_reset_active;
  logic seen_req = 1'b0;
  rcs_addr_t cpu_addr = 16'h0000, dbg_addr;
  rcs_byte_t cpu_wdata = 8'h00, gdat = 8'h00, dbg_wdata, cpu_rdata, exp_c;
  logic [14:0] s = 15'h0852;
  logic [31:0] lfsr = 32'd92974;
  int n_mismatch = 0, comparisons = 0, cyc = 0;
  always #10 core_clk = ~core_clk;
  rcs_host_model u_rcs_host_model (.core_clk(core_clk), .rstn(rstn), .go(go), .data(gdat),
    .dbg_addr(dbg_addr), .dbg_wdata(dbg_wdata), .dbg_wr(dbg_wr));
  rcs_top u_rcs_top (.core_clk(core_clk), .rstn(rstn), .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata),
    .dbg_addr(dbg_addr), .dbg_wdata(dbg_wdata), .dbg_wr(dbg_wr), .reset_pin_n(~s[14]),
    .watchdog_timeout(s[0]), .watchdog_enable(s[1]), .opcode_illegal(s[2]), .halt_exec(s[3]),
    .halt_enable(s[4]), .debug_halt_instruction(s[5]), .debug_mode_enable(s[6]),
    .address_illegal(s[7]), .osc_reset_req(s[8]), .supply_low(s[9]), .stop_mode(s[10]),
    .brownout_reset_enable(s[11]), .brownout_stop_enable(s[12]),
    .undervoltage_reset(s[13]), .mcu_reset_req(mcu_reset_req),
    .sys_reset_active(sys_reset_active));
  // ----------------------------------------
  // expectations
  // ----------------------------------------
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // {host force, source flips, reset expected, cause}
  function automatic logic [24:0] tcase(input int k);
    case (k)
      0: return {1'b0, 15'h0001, 9'h120};
      1: return {1'b0, 15'h0004, 9'h110};
      2: return {1'b0, 15'h0018, 9'h110};
      3: return {1'b0, 15'h0060, 9'h110};
      4: return {1'b0, 15'h0080, 9'h108};
      5: return {1'b0, 15'h0100, 9'h104};
      6: return {1'b0, 15'h0200, 9'h102};
      7: return {1'b0, 15'h2000, 9'h102};
      8: return {1'b0, 15'h4000, 9'h140};
      9: return {1'b1, 15'h0000, 9'h100};
      10: return {1'b0, 15'h0003, 9'h000};
      11: return {1'b0, 15'h0008, 9'h000};
      12: return {1'b0, 15'h0600, 9'h000};
      default: return {1'b0, 15'h1600, 9'h102};
    endcase
  endfunction
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input rcs_byte_t got, input rcs_byte_t exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input rcs_addr_t a, input rcs_byte_t e);
    cpu_addr <= a;
    cpu_rd <= 1'b1;
    @(posedge core_clk);
    cpu_rd <= 1'b0;
    @(negedge core_clk);
    chk(cpu_rdata, e);
    @(posedge core_clk);
  endtask
  task automatic run(input int k);
    logic [24:0] t;
    t = tcase(k);
    lfsr = nx(lfsr);
    // cpu write of random data, must never reach either register
    cpu_addr <= {15'h1800, lfsr[0]};
    cpu_wdata <= lfsr[8:1];
    cpu_wr <= 1'b1;
    @(posedge core_clk);
    seen = 1'b0;
    seen_req = 1'b0;
    cpu_wr <= 1'b0;
    s <= s ^ t[23:9];
    go <= t[24];
    gdat <= {lfsr[7:1], 1'b1};
    @(posedge core_clk);
    go <= 1'b0;
    repeat (6) @(posedge core_clk);
    s <= 15'h0852;
    repeat (12) @(posedge core_clk);
    if (t[8]) exp_c = t[7:0];
    chk({7'h00, seen}, {7'h00, t[8]});
    chk({7'h00, seen_req}, {7'h00, t[8]});
    rd(16'h3000, exp_c);
    rd(16'h3001, 8'h00);
  endtask
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // monitors and main sequence
  // ----------------------------------------
  // combinational outputs are looked at mid-cycle, clear of the launching edge
  always @(negedge core_clk) begin
    if (sys_reset_active === 1'b1) seen = 1'b1;
    if (mcu_reset_req === 1'b1) seen_req = 1'b1;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      stop_test;
    end
  end
  initial begin
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    exp_c = 8'h82;
    rd(16'h3000, 8'h82);
    rd(16'h3001, 8'h00);
    for (int i = 0; i < 30; i++) begin
      lfsr = nx(lfsr);
      run(i < 14 ? i : int'(lfsr[7:0] % 14));
    end
    stop_test;
  end
endmodule // tb
`default_nettype wire
